// *** verilog/bcc_core.sv ***
// Calendar clock core: time base, BCD calendar, registers, pins
//
// Contract
// - Count seconds from the 32.768 kHz crystal time base.
// - All time values in BCD; same eight registers set and read.
// - Seconds, minutes, hours at addresses 0-2; 00-59, 00-59, 00-23.
// - Hours bit 7 enables century flag bit 6 toggling at rollover.
// - Address 3 low three bits hold day of week 01-07.
// - Addresses 4-6 hold date 01-31, month 01-12, year 00-99.
// - Halt bit, address 0 bit 7, stops the time base; clear restarts.
// - After halt clears the time base runs again within four seconds.
// - Clock registers read singly or in sequence; control alone. The pointer still steps through address 7 and wraps to 0 inside a sequence.
// - Reading a clock register holds off visible updates up to 250 ms.
// - Deferred update loses no time; internal count keeps running.
// - Open-drain level pin follows control bit 7; low when zero.
// - Fail flag, address 1 bit 7, sets whenever the oscillator stops.
// - Fail flag stays set until the master writes it to zero.
// - At power-up level bit and fail flag are 1, halt bit 0.
// - Slave address D0h; device acknowledges address, word, data bytes.
// - Pointer loaded by word address, incremented on acknowledged byte.
// - Read without word address starts at the pointer last held.
`timescale 1ns/1ps
`default_nettype none
module bcc_core
  import bcc_pkg::*;
#(
  parameter int OSC_EDGES   = OSC_HZ,
  parameter int HOLD_CYCLES = HOLD_CYC,
  parameter int STOP_CYCLES = STOP_CYC
) (
  // Clock and reset
  input  wire logic clock_in,
  input  wire logic rst_in,
  // Crystal time base
  input  wire logic osc_clk_in,
  // Serial pins
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_n_out,
  // Level output pin
  output logic      level_out,
  output logic      level_oe_n_out
);
  import bcc_pkg::*;

  localparam int SW = $clog2(OSC_EDGES);
  localparam int IW = $clog2(STOP_CYCLES + 1);
  localparam int HW = $clog2(HOLD_CYCLES + 1);

  if (OSC_EDGES < 2 || HOLD_CYCLES < 1 || STOP_CYCLES < 2) begin : g_bad
    $error("bcc_core: parameter out of range");
  end

  bcc_reg_if rif ();

  bcc_i2c_slave u_slave (
    .clock_in     (clock_in),
    .rst_in       (rst_in),
    .scl_in       (scl_in),
    .sda_in       (sda_in),
    .sda_out      (sda_out),
    .sda_oe_n_out (sda_oe_n_out),
    .rif          (rif)
  );

  // --------------------------------------------------------------------
  // Time base
  // --------------------------------------------------------------------
  logic [2:0]    osc_sy;
  logic          osc_f, next_osc_f, osc_edge;
  logic [SW-1:0] sub, next_sub;
  logic [IW-1:0] idle, next_idle;
  logic          tick, next_tick;
  logic          stopped, next_stopped;
  logic          halt, sec_wr;

  always_comb begin
    next_osc_f   = (osc_sy[1] == osc_sy[2]) ? osc_sy[2] : osc_f;
    osc_edge     = !osc_f && next_osc_f;
    next_sub     = sub;
    next_tick    = 1'b0;
    next_idle    = idle;
    if (halt || sec_wr) begin
      next_sub = '0;
    end else if (osc_edge) begin
      if (sub == SW'(OSC_EDGES - 1)) begin
        next_sub  = '0;
        next_tick = 1'b1;
      end else begin
        next_sub = sub + 1'b1;
      end
    end
    if (osc_edge) begin
      next_idle = '0;
    end else if (idle != IW'(STOP_CYCLES)) begin
      next_idle = idle + 1'b1;
    end
    next_stopped = halt || (next_idle == IW'(STOP_CYCLES));
  end

  always_ff @(posedge clock_in) begin
    osc_sy <= {osc_sy[1:0], osc_clk_in};
    if (rst_in) begin
      osc_f   <= 1'b0;
      sub     <= '0;
      idle    <= '0;
      tick    <= 1'b0;
      stopped <= 1'b0;
    end else begin
      osc_f   <= next_osc_f;
      sub     <= next_sub;
      idle    <= next_idle;
      tick    <= next_tick;
      stopped <= next_stopped;
    end
  end

  // --------------------------------------------------------------------
  // Calendar arithmetic
  // --------------------------------------------------------------------
  bcc_byte_t t [NREG-1];
  bcc_byte_t v [NREG-1];
  bcc_byte_t next_t [NREG-1];
  bcc_byte_t next_v [NREG-1];
  bcc_byte_t ctl, next_ctl;
  logic      fail, next_fail;
  logic [HW-1:0] hcnt, next_hcnt;
  logic      hold;
  logic [8:0] s_sec, s_min, s_hr, s_dow, s_date, s_mon, s_yr;
  logic      c_min, c_hr, c_day, c_mon, c_yr;

  // Increment a BCD byte, wrap to lo at or past hi
  function automatic logic [8:0] bcd_step(input bcc_byte_t x,
                                          input bcc_byte_t lo,
                                          input bcc_byte_t hi);
    if (x >= hi) return {1'b1, lo};
    if (x[3:0] == BCD_NINE) return {1'b0, x + BCD_ADJ};
    return {1'b0, x + BCD_ONE};
  endfunction

  // Last day of the month, leap years every fourth year
  function automatic bcc_byte_t month_len(input bcc_byte_t m,
                                          input bcc_byte_t y);
    logic leap;
    leap = (!y[4] && (y[3:0] == 4'h0 || y[3:0] == 4'h4 ||
                      y[3:0] == 4'h8)) ||
           (y[4] && (y[3:0] == 4'h2 || y[3:0] == 4'h6));
    if (m == MON_FEB) return leap ? BCD_D29 : BCD_D28;
    if (m == MON_APR || m == MON_JUN || m == MON_SEP || m == MON_NOV)
      return BCD_D30;
    return BCD_D31;
  endfunction

  always_comb begin
    s_sec  = bcd_step({1'b0, t[REG_SEC][6:0]}, BCD_ZERO, BCD_SEC_MAX);
    s_min  = bcd_step({1'b0, t[REG_MIN][6:0]}, BCD_ZERO, BCD_SEC_MAX);
    s_hr   = bcd_step({2'b00, t[REG_HR][5:0]}, BCD_ZERO, BCD_HR_MAX);
    s_dow  = bcd_step({5'h00, t[REG_DOW][2:0]}, BCD_ONE, BCD_DOW_MAX);
    s_date = bcd_step({2'b00, t[REG_DATE][5:0]}, BCD_ONE,
                      month_len({3'h0, t[REG_MON][4:0]}, t[REG_YR]));
    s_mon  = bcd_step({3'h0, t[REG_MON][4:0]}, BCD_ONE, BCD_MON_MAX);
    s_yr   = bcd_step(t[REG_YR], BCD_ZERO, BCD_YR_MAX);
    c_min  = s_sec[8];
    c_hr   = c_min && s_min[8];
    c_day  = c_hr && s_hr[8];
    c_mon  = c_day && s_date[8];
    c_yr   = c_mon && s_mon[8];
  end

  // --------------------------------------------------------------------
  // Registers, read hold and flags
  // --------------------------------------------------------------------
  assign halt   = t[REG_SEC][BIT_HALT];
  assign sec_wr = rif.wr_stb && (rif.addr == REG_SEC);
  assign hold   = rif.rd_clock && (hcnt < HW'(HOLD_CYCLES));

  always_comb begin
    next_t = t;
    if (tick) begin
      next_t[REG_SEC][6:0] = s_sec[6:0];
      if (c_min) next_t[REG_MIN][6:0] = s_min[6:0];
      if (c_hr) next_t[REG_HR][5:0] = s_hr[5:0];
      if (c_day) begin
        next_t[REG_DOW][2:0]  = s_dow[2:0];
        next_t[REG_DATE][5:0] = s_date[5:0];
      end
      if (c_mon) next_t[REG_MON][4:0] = s_mon[4:0];
      if (c_yr) next_t[REG_YR] = s_yr[7:0];
      if (s_yr[8] && c_yr && t[REG_HR][BIT_CEN_EN])
        next_t[REG_HR][BIT_CEN_FLG] = !t[REG_HR][BIT_CEN_FLG];
    end
    // Visible copy follows the running count unless a read holds it
    for (int i = 0; i < NREG - 1; i++) begin
      next_v[i] = hold ? v[i] : t[i];
    end
    next_ctl  = ctl;
    next_fail = fail;
    next_hcnt = rif.rd_clock ?
                (hold ? hcnt + 1'b1 : hcnt) : '0;
    if (rif.wr_stb) begin
      if (rif.addr == REG_CTL) begin
        next_ctl = rif.wr_data;
      end else begin
        next_t[rif.addr] = rif.wr_data;
        next_v[rif.addr] = rif.wr_data;
      end
      if (rif.addr == REG_MIN && !rif.wr_data[BIT_FAIL])
        next_fail = 1'b0;
    end
    if (stopped) next_fail = 1'b1;
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      t    <= '{default: BCD_ZERO};
      v    <= '{default: BCD_ZERO};
      ctl  <= RST_CTL;
      fail <= 1'b1;
      hcnt <= '0;
    end else begin
      t    <= next_t;
      v    <= next_v;
      ctl  <= next_ctl;
      fail <= next_fail;
      hcnt <= next_hcnt;
    end
  end

  // Read mux: clock bytes from the visible copy
  always_comb begin
    if (rif.addr == REG_CTL) rif.rd_data = ctl;
    else if (rif.addr == REG_MIN)
      rif.rd_data = {fail, v[REG_MIN][6:0]};
    else rif.rd_data = v[rif.addr];
  end

  assign level_out      = 1'b0;
  assign level_oe_n_out = ctl[BIT_LEVEL];

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);

  sequence sec_wrap;
    tick && (t[REG_SEC][6:0] == BCD_SEC_MAX[6:0]) && !rif.wr_stb;
  endsequence

  chk_fail_sticky: assert property (fail && !(rif.wr_stb &&
    rif.addr == REG_MIN && !rif.wr_data[BIT_FAIL]) |=> fail)
    else $error("fail flag dropped without a clearing write");
  chk_stop_sets_fail: assert property (stopped |=> fail)
    else $error("fail flag not set after a stop");
  chk_halt_no_tick: assert property (halt |=> !tick)
    else $error("second advanced while halted");
  chk_level_pin: assert property (rif.wr_stb && rif.addr == REG_CTL
    |=> level_oe_n_out == $past(rif.wr_data[BIT_LEVEL]))
    else $error("level pin does not follow control bit");
  chk_hold_frozen: assert property (hold && !rif.wr_stb
    |=> $stable(v[REG_SEC]) && $stable(v[REG_MIN]))
    else $error("visible time changed during a read");
  chk_copy_tracks: assert property (!hold && !rif.wr_stb
    |=> v[REG_SEC] == $past(t[REG_SEC]))
    else $error("visible copy lags the running count");
  chk_sec_roll: assert property (sec_wrap |=>
    t[REG_SEC][6:0] == BCD_ZERO[6:0] &&
    t[REG_MIN] != $past(t[REG_MIN]))
    else $error("seconds did not roll into minutes");
  chk_power_defaults: assert property (disable iff (1'b0)
    rst_in |=> fail && ctl[BIT_LEVEL] && !halt)
    else $error("power-up defaults wrong");

  // --------------------------------------------------------------------
  // Register and rollover checks
  // --------------------------------------------------------------------
  sequence min_wrap;
    sec_wrap ##0 (t[REG_MIN][6:0] == BCD_SEC_MAX[6:0]);
  endsequence

  chk_min_roll: assert property (min_wrap |=>
    t[REG_MIN][6:0] == BCD_ZERO[6:0] &&
    t[REG_HR] != $past(t[REG_HR]))
    else $error("minutes did not roll into hours");
  chk_cent_keep: assert property (tick && !rif.wr_stb &&
    !t[REG_HR][BIT_CEN_EN] |=> t[REG_HR][BIT_CEN_FLG] ==
    $past(t[REG_HR][BIT_CEN_FLG])) else $error("century flag moved");
  chk_halt_stops: assert property (halt |=> stopped)
    else $error("halt not seen as a stop");
  chk_fail_clear: assert property (rif.wr_stb && !stopped &&
    rif.addr == REG_MIN && !rif.wr_data[BIT_FAIL] |=> !fail)
    else $error("fail flag not cleared by write");
  chk_ctl_store: assert property (rif.wr_stb && rif.addr == REG_CTL
    |=> ctl == $past(rif.wr_data)) else $error("control not stored");
  chk_wr_lands: assert property (rif.wr_stb && rif.addr != REG_CTL
    |=> t[$past(rif.addr)] == $past(rif.wr_data))
    else $error("clock register write lost");
endmodule
`default_nettype wire

// *** verilog/bcc_pkg.sv ***
// Constants, states and types shared by the calendar clock core files
package bcc_pkg;
  localparam logic [6:0] DEV_ADDR    = 7'h68;
  localparam int         NREG        = 8;
  localparam logic [2:0] REG_SEC     = 3'h0;
  localparam logic [2:0] REG_MIN     = 3'h1;
  localparam logic [2:0] REG_HR      = 3'h2;
  localparam logic [2:0] REG_DOW     = 3'h3;
  localparam logic [2:0] REG_DATE    = 3'h4;
  localparam logic [2:0] REG_MON     = 3'h5;
  localparam logic [2:0] REG_YR      = 3'h6;
  localparam logic [2:0] REG_CTL     = 3'h7;
  localparam int         BIT_HALT    = 7;
  localparam int         BIT_FAIL    = 7;
  localparam int         BIT_CEN_EN  = 7;
  localparam int         BIT_CEN_FLG = 6;
  localparam int         BIT_LEVEL   = 7;
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [3:0] BCD_NINE    = 4'h9;
  localparam logic [7:0] BCD_ADJ     = 8'h07;
  localparam logic [7:0] BCD_ZERO    = 8'h00;
  localparam logic [7:0] BCD_ONE     = 8'h01;
  localparam logic [7:0] BCD_SEC_MAX = 8'h59;
  localparam logic [7:0] BCD_HR_MAX  = 8'h23;
  localparam logic [7:0] BCD_DOW_MAX = 8'h07;
  localparam logic [7:0] BCD_MON_MAX = 8'h12;
  localparam logic [7:0] BCD_YR_MAX  = 8'h99;
  localparam logic [7:0] BCD_D28     = 8'h28;
  localparam logic [7:0] BCD_D29     = 8'h29;
  localparam logic [7:0] BCD_D30     = 8'h30;
  localparam logic [7:0] BCD_D31     = 8'h31;
  localparam logic [7:0] MON_FEB     = 8'h02;
  localparam logic [7:0] MON_APR     = 8'h04;
  localparam logic [7:0] MON_JUN     = 8'h06;
  localparam logic [7:0] MON_SEP     = 8'h09;
  localparam logic [7:0] MON_NOV     = 8'h11;
  localparam logic [7:0] RST_CTL     = 8'h80;
  localparam int         CLK_HZ      = 125_000_000;
  localparam int         OSC_HZ      = 32768;
  localparam int         HOLD_MS     = 250;
  localparam int         HOLD_CYC    = HOLD_MS * (CLK_HZ / 1000);
  localparam int         STOP_US     = 100;
  localparam int         STOP_CYC    = STOP_US * (CLK_HZ / 1_000_000);
  typedef logic [7:0] bcc_byte_t;
  typedef enum logic [8:0] {
    S_IDLE  = 9'h001,
    S_ADDR  = 9'h002,
    S_AACK  = 9'h004,
    S_WORD  = 9'h008,
    S_WACK  = 9'h010,
    S_WDATA = 9'h020,
    S_DACK  = 9'h040,
    S_RDATA = 9'h080,
    S_RACK  = 9'h100
  } bcc_state_e;
endpackage

// *** verilog/bcc_reg_if.sv ***
// Register access path between the serial slave and the clock core
`timescale 1ns/1ps
`default_nettype none
interface bcc_reg_if;
  logic       wr_stb;
  logic [2:0] addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic       rd_clock;
  modport slave (output wr_stb, addr, wr_data, rd_clock, input rd_data);
  modport core  (input wr_stb, addr, wr_data, rd_clock, output rd_data);
endinterface
`default_nettype wire

// *** verilog/bcc_i2c_slave.sv ***
// Two-wire serial slave with auto-incrementing register pointer
`timescale 1ns/1ps
`default_nettype none
module bcc_i2c_slave
  import bcc_pkg::*;
(
  // Clock and reset
  input  wire logic   clock_in,
  input  wire logic   rst_in,
  // Serial pins
  input  wire logic   scl_in,
  input  wire logic   sda_in,
  output logic        sda_out,
  output logic        sda_oe_n_out,
  // Register path
  bcc_reg_if.slave    rif
);
  import bcc_pkg::*;

  logic [2:0] scl_sy, sda_sy;
  logic       scl_f, sda_f, next_scl_f, next_sda_f;
  logic       rise, fall, start, stop;
  bcc_state_e fsm, next_fsm;
  logic [3:0] cnt, next_cnt;
  logic [7:0] sr, next_sr, tx, next_tx;
  logic [2:0] ptr, next_ptr;
  logic       rw, next_rw, ack, next_ack;
  logic       wr, next_wr, drv, next_drv;

  // --------------------------------------------------------------------
  // Pin filtering and bus conditions
  // --------------------------------------------------------------------
  always_comb begin
    next_scl_f = (scl_sy[1] == scl_sy[2]) ? scl_sy[2] : scl_f;
    next_sda_f = (sda_sy[1] == sda_sy[2]) ? sda_sy[2] : sda_f;
    rise  = !scl_f && next_scl_f;
    fall  = scl_f && !next_scl_f;
    start = scl_f && next_scl_f && sda_f && !next_sda_f;
    stop  = scl_f && next_scl_f && !sda_f && next_sda_f;
  end

  // --------------------------------------------------------------------
  // Protocol state machine
  // --------------------------------------------------------------------
  always_comb begin
    next_fsm = fsm;
    next_cnt = cnt;
    next_sr  = sr;
    next_tx  = tx;
    next_ptr = ptr;
    next_rw  = rw;
    next_ack = ack;
    next_wr  = 1'b0;
    if (start) begin
      next_fsm = S_ADDR;
      next_cnt = '0;
    end else if (stop) begin
      next_fsm = S_IDLE;
    end else if (rise) begin
      next_cnt = cnt + 4'h1;
      next_sr  = {sr[6:0], next_sda_f};
      if (fsm == S_RACK) next_ack = !next_sda_f;
    end else if (fall) begin
      case (fsm)
        S_ADDR: if (cnt == BYTE_BITS) begin
          next_cnt = '0;
          next_rw  = sr[0];
          next_fsm = (sr[7:1] == DEV_ADDR) ? S_AACK : S_IDLE;
        end
        S_AACK: begin
          next_cnt = '0;
          next_tx  = rif.rd_data;
          next_fsm = rw ? S_RDATA : S_WORD;
        end
        S_WORD: if (cnt == BYTE_BITS) begin
          next_cnt = '0;
          next_ptr = sr[2:0];
          next_fsm = S_WACK;
        end
        S_WACK: begin
          next_cnt = '0;
          next_fsm = S_WDATA;
        end
        S_WDATA: if (cnt == BYTE_BITS) begin
          next_cnt = '0;
          next_wr  = 1'b1;
          next_fsm = S_DACK;
        end
        S_DACK: begin
          next_cnt = '0;
          next_ptr = ptr + 3'h1;
          next_fsm = S_WDATA;
        end
        S_RDATA: if (cnt == BYTE_BITS) begin
          next_cnt = '0;
          next_fsm = S_RACK;
        end else begin
          next_tx = {tx[6:0], 1'b0};
        end
        S_RACK: begin
          next_cnt = '0;
          if (ack) begin
            next_ptr = ptr + 3'h1;
            next_tx  = rif.rd_data;
            next_fsm = S_RDATA;
          end else begin
            next_fsm = S_IDLE;
          end
        end
        default: next_fsm = S_IDLE;
      endcase
    end
    next_drv = (next_fsm == S_AACK) || (next_fsm == S_WACK) ||
               (next_fsm == S_DACK) ||
               ((next_fsm == S_RDATA) && !next_tx[7]);
  end

  always_ff @(posedge clock_in) begin
    scl_sy <= {scl_sy[1:0], scl_in};
    sda_sy <= {sda_sy[1:0], sda_in};
    if (rst_in) begin
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      fsm   <= S_IDLE;
      cnt   <= '0;
      sr    <= '0;
      tx    <= '0;
      ptr   <= '0;
      rw    <= 1'b0;
      ack   <= 1'b0;
      wr    <= 1'b0;
      drv   <= 1'b0;
    end else begin
      scl_f <= next_scl_f;
      sda_f <= next_sda_f;
      fsm   <= next_fsm;
      cnt   <= next_cnt;
      sr    <= next_sr;
      tx    <= next_tx;
      ptr   <= next_ptr;
      rw    <= next_rw;
      ack   <= next_ack;
      wr    <= next_wr;
      drv   <= next_drv;
    end
  end

  // Look one entry ahead while an acknowledged read moves on
  assign rif.addr     = (fsm == S_RACK && ack) ? ptr + 3'h1 : ptr;
  assign rif.wr_stb   = wr;
  assign rif.wr_data  = sr;
  assign rif.rd_clock = ((fsm == S_RDATA) || (fsm == S_RACK)) &&
                        (ptr != REG_CTL);
  assign sda_out      = 1'b0;
  assign sda_oe_n_out = !drv;

  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);

  chk_ptr_wrap: assert property (ptr == REG_CTL && fsm == S_DACK && fall
    |=> ptr == REG_SEC) else $error("pointer did not wrap");
endmodule
`default_nettype wire

// *** dv/bcc_i2c_master.sv ***
// Behavioural two-wire bus master driving the clock core's serial pins
`timescale 1ns/1ps
`default_nettype none
module bcc_i2c_master #(
  parameter int HALF = 8
) (
  // Clock
  input  wire logic clock_in,
  // Bus lines
  input  wire logic sda_in,
  output var logic  scl_out,
  output var logic  sda_low_out
);
  initial begin
    scl_out     = 1'b1;
    sda_low_out = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  // Data moves only while the clock line is low
  task automatic put_bit(input logic b);
    tick(2);
    sda_low_out = !b;
    tick(HALF);
    scl_out = 1'b1;
    tick(HALF);
    scl_out = 1'b0;
  endtask

  task automatic get_bit(output logic b);
    tick(2);
    sda_low_out = 1'b0;
    tick(HALF);
    scl_out = 1'b1;
    tick(HALF / 2);
    b = sda_in;
    tick(HALF / 2);
    scl_out = 1'b0;
  endtask

  // Also serves as a repeated start
  task automatic start_cond;
    tick(2);
    sda_low_out = 1'b0;
    tick(HALF);
    scl_out = 1'b1;
    tick(HALF);
    sda_low_out = 1'b1;
    tick(HALF);
    scl_out = 1'b0;
  endtask

  task automatic stop_cond;
    tick(2);
    sda_low_out = 1'b1;
    tick(HALF);
    scl_out = 1'b1;
    tick(HALF);
    sda_low_out = 1'b0;
    tick(HALF);
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(b);
    ack = !b;
  endtask

  // Master acknowledges all but the last byte
  task automatic rd_byte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(last);
  endtask
endmodule
`default_nettype wire

// *** dv/bcd_calendar_clock_core_tb_top.sv ***
// Self-checking bench for the calendar clock core
`timescale 1ns/1ps
`default_nettype none
module bcd_calendar_clock_core_tb_top;
  import bcc_pkg::*;
  localparam int EDGES = 4;
  logic      clock_in  = 1'b0;
  logic      rst_in    = 1'b1;
  logic      osc_clk   = 1'b0;
  logic      osc_run   = 1'b0;
  logic      scl;
  logic      sda_low;
  logic      sda_out;
  logic      sda_oe_n;
  logic      level_out;
  logic      level_oe_n;
  logic      ack;
  wire logic sda_line;
  int        err_count = 0;
  int        n_tests   = 0;
  int        seed      = 82;
  bcc_byte_t wbuf[8];
  bcc_byte_t rbuf[9];
  bcc_byte_t ex[9];
  bcc_byte_t roll_tbl[6][4] = '{
    '{8'h31, 8'h12, 8'h99, 8'hA3}, '{8'h31, 8'h12, 8'h99, 8'h63},
    '{8'h28, 8'h02, 8'h04, 8'h23}, '{8'h29, 8'h02, 8'h04, 8'h23},
    '{8'h28, 8'h02, 8'h03, 8'hE3}, '{8'h30, 8'h04, 8'h21, 8'h23}};

  always #4 clock_in = ~clock_in;
  // Crystal stands still unless running free or pulsed
  always begin
    #32;
    if (osc_run) osc_clk = ~osc_clk;
  end
  // Pull-up on the data line
  assign sda_line = (sda_low || !sda_oe_n) ? 1'b0 : 1'b1;

  bcc_core #(.OSC_EDGES(EDGES), .HOLD_CYCLES(200), .STOP_CYCLES(64)) DUT (
    .clock_in(clock_in), .rst_in(rst_in), .osc_clk_in(osc_clk),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe_n_out(sda_oe_n), .level_out(level_out),
    .level_oe_n_out(level_oe_n));
  bcc_i2c_master mst (.clock_in(clock_in), .sda_in(sda_line),
    .scl_out(scl), .sda_low_out(sda_low));

  //----------------------------------------------------------------
  // Helpers
  //----------------------------------------------------------------
  function automatic int b2i(bcc_byte_t b);
    return b[7:4] * 10 + b[3:0];
  endfunction
  function automatic bcc_byte_t i2b(int v);
    return bcc_byte_t'((v / 10) * 16 + v % 10);
  endfunction
  function automatic int mdays(int m, int y);
    if (m == 2) return (y % 4 == 0) ? 29 : 28;
    if (m == 4 || m == 6 || m == 9 || m == 11) return 30;
    return 31;
  endfunction

  task automatic chk(input bcc_byte_t got, input bcc_byte_t exp,
                     input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr_regs(input logic [2:0] a, input int n);
    mst.start_cond();
    mst.wr_byte({DEV_ADDR, 1'b0}, ack);
    chk({7'h00, ack}, 8'h01, "address ack");
    mst.wr_byte({5'h00, a}, ack);
    chk({7'h00, ack}, 8'h01, "word ack");
    for (int i = 0; i < n; i++) begin
      mst.wr_byte(wbuf[i], ack);
      chk({7'h00, ack}, 8'h01, "data ack");
    end
    mst.stop_cond();
  endtask

  task automatic rd_regs(input logic set, input logic [2:0] a, input int n);
    if (set) begin
      mst.start_cond();
      mst.wr_byte({DEV_ADDR, 1'b0}, ack);
      mst.wr_byte({5'h00, a}, ack);
    end
    mst.start_cond();
    mst.wr_byte({DEV_ADDR, 1'b1}, ack);
    chk({7'h00, ack}, 8'h01, "read ack");
    for (int i = 0; i < n; i++) mst.rd_byte(i == n - 1, rbuf[i]);
    mst.stop_cond();
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      #32 osc_clk = 1'b1;
      #32 osc_clk = 1'b0;
    end
  endtask

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #600_000;
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    give_verdict();
  end

  //----------------------------------------------------------------
  // Main sequence
  //----------------------------------------------------------------
  initial begin
    int d, m, y, dw;
    bcc_byte_t hr;
    repeat (8) @(posedge clock_in);
    #1 rst_in = 1'b0;
    repeat (4) @(posedge clock_in);
    // Power-on values, pointer reuse and wrap
    ex = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
    rd_regs(1'b0, 3'h0, 9);
    for (int i = 0; i < 9; i++) chk(rbuf[i], ex[i], "reset");
    chk({7'h00, level_oe_n}, 8'h01, "level reset");
    chk({7'h00, sda_out}, 8'h00, "sda value");
    // Random write then block and single read-back
    for (int k = 0; k < 4; k++) begin
      wbuf[0] = i2b($unsigned($random(seed)) % 60);
      wbuf[1] = i2b($unsigned($random(seed)) % 60);
      wbuf[2] = i2b($unsigned($random(seed)) % 24)
                | {2'($random(seed)), 6'h00};
      wbuf[3] = i2b($unsigned($random(seed)) % 7 + 1);
      wbuf[4] = i2b($unsigned($random(seed)) % 28 + 1);
      wbuf[5] = i2b($unsigned($random(seed)) % 12 + 1);
      wbuf[6] = i2b($unsigned($random(seed)) % 100);
      wbuf[7] = {k[0], 1'b0, 6'($random(seed))};
      wr_regs(3'h0, 8);
      rd_regs(1'b1, 3'h0, 7);
      for (int i = 0; i < 7; i++)
        chk(rbuf[i], (i == 1) ? (wbuf[1] | 8'h80) : wbuf[i], "rdback");
      rd_regs(1'b1, 3'h7, 1);
      chk(rbuf[0], wbuf[7], "control");
      chk({7'h00, level_oe_n}, {7'h00, wbuf[7][7]}, "level");
      chk({7'h00, level_out}, 8'h00, "level low");
    end
    // Calendar and century rollover after one second
    for (int k = 0; k < 6; k++) begin
      dw = $unsigned($random(seed)) % 7 + 1;
      wbuf[0] = 8'h59;
      wbuf[1] = 8'h59;
      wbuf[2] = roll_tbl[k][3];
      wbuf[3] = i2b(dw);
      wbuf[4] = roll_tbl[k][0];
      wbuf[5] = roll_tbl[k][1];
      wbuf[6] = roll_tbl[k][2];
      wr_regs(3'h0, 7);
      pulses(EDGES);
      rd_regs(1'b1, 3'h0, 7);
      d = b2i(wbuf[4]) + 1;
      m = b2i(wbuf[5]);
      y = b2i(wbuf[6]);
      hr = wbuf[2] & 8'hC0;
      if (d > mdays(m, y)) begin
        d = 1;
        m++;
      end
      if (m > 12) begin
        m = 1;
        y = (y + 1) % 100;
        if (y == 0 && hr[7]) hr[6] = !hr[6];
      end
      ex = '{8'h00, 8'h80, hr, i2b(dw % 7 + 1), i2b(d), i2b(m), i2b(y),
             8'h00, 8'h00};
      for (int i = 0; i < 7; i++) chk(rbuf[i], ex[i], "roll");
    end
    // Halt, fail flag stickiness and clearing
    wbuf[0] = 8'h90;
    wr_regs(3'h0, 1);
    pulses(2 * EDGES);
    rd_regs(1'b1, 3'h0, 2);
    chk(rbuf[0], 8'h90, "halted");
    chk(rbuf[1] & 8'h80, 8'h80, "fail set");
    wbuf[0] = 8'h10;
    wr_regs(3'h0, 1);
    osc_run = 1'b1;
    repeat (48 * EDGES) @(posedge clock_in);
    #1;
    rd_regs(1'b1, 3'h0, 2);
    chk({7'h00, rbuf[0] != 8'h10}, 8'h01, "restart");
    chk(rbuf[1] & 8'h80, 8'h80, "fail sticky");
    wbuf[0] = 8'h00;
    wr_regs(3'h1, 1);
    rd_regs(1'b1, 3'h1, 1);
    chk(rbuf[0] & 8'h80, 8'h00, "fail cleared");
    wbuf[0] = 8'h80;
    wr_regs(3'h0, 1);
    rd_regs(1'b1, 3'h1, 1);
    chk(rbuf[0] & 8'h80, 8'h80, "halt sets fail");
    osc_run = 1'b0;
    // Foreign slave address is not acknowledged
    mst.start_cond();
    mst.wr_byte(8'hA0, ack);
    chk({7'h00, ack}, 8'h00, "foreign");
    mst.stop_cond();
    give_verdict();
  end
endmodule
`default_nettype wire
